// ---- core/clk_divider.sv ----
// Divider for the secondary clock: pass, half or quarter rate
`timescale 1ns/1ps
`default_nettype none
module clk_divider (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         src_i,
    input  wire dll_pkg::div_e sel_i,
    output logic              clk_o
);
    import dll_pkg::*;

    div_state_s s_q;
    div_state_s s_d;

    always_comb begin
        s_d     = s_q;
        s_d.src = src_i;
        if (src_i && !s_q.src) begin
            s_d.cnt = s_q.cnt + 2'h1;
        end
        unique case (sel_i)
            DIV_1: s_d.out = s_q.src;
            DIV_2: s_d.out = s_q.cnt[0];
            DIV_4: s_d.out = s_q.cnt[1];
            default: s_d.out = s_q.cnt[1];
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign clk_o = s_q.out;
endmodule
`default_nettype wire

// ---- core/dll_delay_calibration.sv ----
// Delay-locked loop with published delay code, secondary clock and slave delay
`timescale 1ns/1ps
`default_nettype none
`include "dll_consts.svh"
module dll_delay_calibration (
    input  wire logic              CLK_I,
    input  wire logic              RST_B_I,
    input  wire dll_pkg::apb_req_s APB_REQ_I,
    output dll_pkg::apb_rsp_s      APB_RSP_O,
    input  wire logic              REF_CLK_IN_I,
    input  wire logic              FEEDBACK_CLK_IN_I,
    input  wire logic              SYNC_RESET_N_I,
    input  wire logic              UPDATE_FREEZE_I,
    input  wire logic              CODE_UPDATE_EN_I,
    output dll_pkg::code_t         DELAY_CODE_O,
    output logic                   PRIMARY_CLK_OUT_O,
    output logic                   SECONDARY_CLK_OUT_O,
    output logic                   LOCK_O,
    output logic                   DELAYED_CLK_OUT_O,
    output logic                   IRQ_O
);
    import dll_pkg::*;

    // ********************************
    // State and helper signals
    // ********************************
    dll_state_s        s_q;
    dll_state_s        s_d;
    logic              loop_rst;
    logic              ref_rise;
    logic              want_up;
    logic              at_limit;
    logic              upd_done;
    logic              setup;
    logic              wr_acc;
    logic [9:0]        phase_sum;
    code_t             sec_sel;
    code_t             slave_sel;
    logic [`IRQ_W-1:0] events;
    logic [`IRQ_W-1:0] w1c;
    logic [31:0]       rd_data;
    logic              rd_err;
    logic              step_ok;
    logic              searching;

    // ********************************
    // Combinational helpers
    // ********************************
    assign loop_rst  = !SYNC_RESET_N_I;
    assign ref_rise  = s_q.ref_s2 && !s_q.ref_s3;
    // Feedback already high at the reference edge: loop delay too short
    assign want_up   = s_q.fb_s2;
    assign at_limit  = want_up ? (s_q.alu_code == `CODE_MAX) : (s_q.alu_code == '0);
    assign upd_done  = CODE_UPDATE_EN_I && s_q.upd_prev;
    assign setup     = APB_REQ_I.psel && !APB_REQ_I.penable;
    assign wr_acc    = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite;
    assign phase_sum = {1'b0, s_q.alu_code} + {1'b0, s_q.phase};
    assign sec_sel   = phase_sum[9] ? `CODE_MAX : phase_sum[8:0];
    // Loop code spans one period, so a quarter of it centres the clock
    assign slave_sel = s_q.slave_man ? s_q.slave_code : {2'h0, s_q.pub_code[8:2]};

    // ********************************
    // Loop step control
    // ********************************
    // Reference edge that may move the code; freeze holds the arithmetic
    assign step_ok   = ref_rise && !UPDATE_FREEZE_I;
    // From the shortest delay the feedback edge lags the reference by less than
    // a period; stepping down would pin the code at zero, so climb until the
    // feedback is first seen high at a reference edge
    assign searching = !s_q.dir_valid && !want_up;

    // ********************************
    // Register read decode
    // ********************************
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        unique case (APB_REQ_I.paddr)
            `OFF_CTRL: begin
                rd_data[`CTRL_DIV_LSB +: 2] = s_q.div_sel;
                rd_data[`CTRL_MAN_BIT]      = s_q.slave_man;
            end
            `OFF_PHASE: begin
                rd_data[8:0] = s_q.phase;
            end
            `OFF_SLAVE: begin
                rd_data[8:0] = s_q.slave_code;
            end
            `OFF_STATUS: begin
                rd_data[0] = (s_q.st == LP_LOCK);
                rd_data[1] = UPDATE_FREEZE_I;
                rd_data[2] = loop_rst;
                rd_data[5:4] = s_q.st;
            end
            `OFF_CODE: begin
                rd_data[8:0]   = s_q.pub_code;
                rd_data[24:16] = s_q.alu_code;
            end
            `OFF_IRQ_STAT: begin
                rd_data[`IRQ_W-1:0] = s_q.irq_stat;
            end
            `OFF_IRQ_MASK: begin
                rd_data[`IRQ_W-1:0] = s_q.irq_mask;
            end
            `OFF_PERIOD: begin
                rd_data[15:0] = s_q.period;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        s_d    = s_q;
        events = '0;
        w1c    = '0;

        // Reference and feedback arrive from pins or other clocks
        s_d.ref_s1 = REF_CLK_IN_I;
        s_d.ref_s2 = s_q.ref_s1;
        s_d.ref_s3 = s_q.ref_s2;
        s_d.fb_s1  = FEEDBACK_CLK_IN_I;
        s_d.fb_s2  = s_q.fb_s1;

        // Reference period measure and loss watch
        if (ref_rise) begin
            s_d.per_cnt   = 16'h0001;
            s_d.period    = s_q.per_cnt;
            s_d.noref_cnt = '0;
        end else begin
            if (s_q.per_cnt != 16'hffff) begin
                s_d.per_cnt = s_q.per_cnt + 16'h0001;
            end
            if (s_q.noref_cnt != `NOREF_LIMIT) begin
                s_d.noref_cnt = s_q.noref_cnt + 8'h01;
            end
        end

        // Loop arithmetic and lock tracking
        if (loop_rst) begin
            s_d.st        = LP_RESET;
            s_d.alu_code  = '0;
            s_d.dir_valid = 1'b0;
            s_d.alt_cnt   = '0;
            s_d.run_cnt   = '0;
            s_d.noref_cnt = '0;
        end else begin
            unique case (s_q.st)
                LP_RESET: begin
                    s_d.st = LP_ACQ;
                end
                LP_ACQ, LP_LOCK: begin
                    if (step_ok && searching) begin
                        if (s_q.alu_code != `CODE_MAX) begin
                            s_d.alu_code = s_q.alu_code + 9'h001;
                        end
                    end else if (step_ok) begin
                        if (!at_limit) begin
                            s_d.alu_code = want_up ? s_q.alu_code + 9'h001
                                                   : s_q.alu_code - 9'h001;
                        end
                        s_d.last_up   = want_up;
                        s_d.dir_valid = 1'b1;
                        if (s_q.dir_valid && (want_up != s_q.last_up)) begin
                            // Dithering about the edge means aligned
                            s_d.run_cnt = '0;
                            if (s_q.alt_cnt != `LOCK_ALT) begin
                                s_d.alt_cnt = s_q.alt_cnt + 4'h1;
                            end
                        end else begin
                            s_d.alt_cnt = '0;
                            if (s_q.run_cnt != `LOSS_RUN) begin
                                s_d.run_cnt = s_q.run_cnt + 4'h1;
                            end
                        end
                    end
                    if (s_q.st == LP_ACQ && s_q.alt_cnt == `LOCK_ALT) begin
                        s_d.st                = LP_LOCK;
                        s_d.alt_cnt           = '0;
                        events[`IRQ_LOCK]     = 1'b1;
                    end
                    if (s_q.st == LP_LOCK) begin
                        if (s_q.run_cnt == `LOSS_RUN || s_q.noref_cnt == `NOREF_LIMIT) begin
                            s_d.st            = LP_ACQ;
                            s_d.run_cnt       = '0;
                            s_d.alt_cnt       = '0;
                            events[`IRQ_LOSS] = 1'b1;
                        end
                    end
                end
                default: begin
                    s_d.st = LP_RESET;
                end
            endcase
        end
        if (s_q.noref_cnt == `NOREF_LIMIT - 8'h01) begin
            events[`IRQ_NOREF] = 1'b1;
        end

        // Two-cycle update request publishes the code
        if (upd_done) begin
            s_d.pub_code     = s_q.alu_code;
            s_d.upd_prev     = 1'b0;
            events[`IRQ_UPD] = 1'b1;
        end else begin
            s_d.upd_prev = CODE_UPDATE_EN_I;
        end

        // Bus slave: data prepared in setup, write takes effect in access
        if (setup) begin
            s_d.prdata  = APB_REQ_I.pwrite ? 32'h0000_0000 : rd_data;
            s_d.pslverr = rd_err;
        end
        if (wr_acc && !s_q.pslverr) begin
            unique case (APB_REQ_I.paddr)
                `OFF_CTRL: begin
                    s_d.div_sel   = div_e'(APB_REQ_I.pwdata[`CTRL_DIV_LSB +: 2]);
                    s_d.slave_man = APB_REQ_I.pwdata[`CTRL_MAN_BIT];
                end
                `OFF_PHASE: begin
                    s_d.phase = APB_REQ_I.pwdata[8:0];
                end
                `OFF_SLAVE: begin
                    s_d.slave_code = APB_REQ_I.pwdata[8:0];
                end
                `OFF_IRQ_STAT: begin
                    w1c = APB_REQ_I.pwdata[`IRQ_W-1:0];
                end
                `OFF_IRQ_MASK: begin
                    s_d.irq_mask = APB_REQ_I.pwdata[`IRQ_W-1:0];
                end
                default: begin
                    s_d.irq_mask = s_q.irq_mask;
                end
            endcase
        end

        // Sticky events; a new event beats a clear in the same cycle
        s_d.irq_stat = (s_q.irq_stat & ~w1c) | events;
        s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************
    // Delay lines and output clocks
    // ********************************
    tap_delay_line u_primary_line (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .din_i   (s_q.ref_s2),
        .sel_i   (s_q.alu_code),
        .dout_o  (PRIMARY_CLK_OUT_O)
    );

    logic sec_phased;

    tap_delay_line u_secondary_line (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .din_i   (s_q.ref_s2),
        .sel_i   (sec_sel),
        .dout_o  (sec_phased)
    );

    clk_divider u_secondary_div (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .src_i   (sec_phased),
        .sel_i   (s_q.div_sel),
        .clk_o   (SECONDARY_CLK_OUT_O)
    );

    // Slave block output drives the DELAYED_CLK_OUT_O port
    tap_delay_line u_slave_line (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .din_i   (s_q.ref_s2),
        .sel_i   (slave_sel),
        .dout_o  (DELAYED_CLK_OUT_O)
    );

    // ********************************
    // Outputs
    // ********************************
    assign DELAY_CODE_O        = s_q.pub_code;
    assign LOCK_O              = (s_q.st == LP_LOCK);
    assign IRQ_O               = s_q.irq;
    assign APB_RSP_O.prdata    = s_q.prdata;
    assign APB_RSP_O.pready    = 1'b1;
    assign APB_RSP_O.pslverr   = s_q.pslverr && APB_REQ_I.psel && APB_REQ_I.penable;
endmodule
`default_nettype wire

// ---- core/tap_delay_line.sv ----
// Tapped delay line with one selected tap, one tap per clock cycle
`timescale 1ns/1ps
`default_nettype none
module tap_delay_line (
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          din_i,
    input  wire dll_pkg::code_t sel_i,
    output logic               dout_o
);
    import dll_pkg::*;

    line_state_s s_q;
    line_state_s s_d;

    always_comb begin
        s_d      = s_q;
        s_d.taps = {s_q.taps[`TAPS-2:0], din_i};
        // Exactly one tap reaches the output
        s_d.out  = s_q.taps[sel_i];
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout_o = s_q.out;
endmodule
`default_nettype wire

// ---- include/dll_consts.svh ----
// Constants for the delay-locked loop and its slave delay block
`ifndef DLL_CONSTS_SVH
`define DLL_CONSTS_SVH

`define CODE_W        9
`define TAPS          512
`define ADDR_W        8
`define OFF_CTRL      8'h00
`define OFF_PHASE     8'h04
`define OFF_SLAVE     8'h08
`define OFF_STATUS    8'h0c
`define OFF_CODE      8'h10
`define OFF_IRQ_STAT  8'h14
`define OFF_IRQ_MASK  8'h18
`define OFF_PERIOD    8'h1c
`define CTRL_DIV_LSB  0
`define CTRL_MAN_BIT  2
`define IRQ_W         4
`define IRQ_LOCK      0
`define IRQ_LOSS      1
`define IRQ_UPD       2
`define IRQ_NOREF     3
`define LOCK_ALT      4'h8
`define LOSS_RUN      4'h4
`define NOREF_LIMIT   8'hff
`define CODE_MAX      9'h1ff

`endif

// ---- include/dll_pkg.sv ----
// Types shared by the delay-locked loop design files
`include "dll_consts.svh"
package dll_pkg;
    typedef logic [`CODE_W-1:0] code_t;
    typedef enum logic [1:0] {DIV_1 = 2'h0, DIV_2 = 2'h1, DIV_4 = 2'h2} div_e;
    typedef enum logic [1:0] {LP_RESET = 2'h0, LP_ACQ = 2'h1, LP_LOCK = 2'h3} loop_e;
    typedef struct packed {
        logic                psel;
        logic                penable;
        logic                pwrite;
        logic [`ADDR_W-1:0]  paddr;
        logic [31:0]         pwdata;
    } apb_req_s;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;
    typedef struct packed {
        logic [`TAPS-1:0] taps;
        logic             out;
    } line_state_s;
    typedef struct packed {
        logic       src;
        logic [1:0] cnt;
        logic       out;
    } div_state_s;
    typedef struct packed {
        logic              ref_s1;
        logic              ref_s2;
        logic              ref_s3;
        logic              fb_s1;
        logic              fb_s2;
        loop_e             st;
        code_t             alu_code;
        code_t             pub_code;
        logic              last_up;
        logic              dir_valid;
        logic [3:0]        alt_cnt;
        logic [3:0]        run_cnt;
        logic [7:0]        noref_cnt;
        logic [15:0]       per_cnt;
        logic [15:0]       period;
        logic              upd_prev;
        div_e              div_sel;
        logic              slave_man;
        code_t             phase;
        code_t             slave_code;
        logic [`IRQ_W-1:0] irq_stat;
        logic [`IRQ_W-1:0] irq_mask;
        logic [31:0]       prdata;
        logic              pslverr;
        logic              irq;
    } dll_state_s;
endpackage

// ---- test/dll_calib_sva.sv ----
// Concurrent checks on the ports of the delay-locked loop
`timescale 1ns/1ps
`default_nettype none
module dll_calib_sva (
    input wire logic           CLK_I,
    input wire logic           RST_B_I,
    input wire logic           REF_CLK_IN_I,
    input wire logic           SYNC_RESET_N_I,
    input wire logic           CODE_UPDATE_EN_I,
    input wire dll_pkg::code_t DELAY_CODE_O,
    input wire logic           PRIMARY_CLK_OUT_O,
    input wire logic           SECONDARY_CLK_OUT_O,
    input wire logic           LOCK_O,
    input wire logic           DELAYED_CLK_OUT_O,
    input wire logic           IRQ_O
);
    import dll_pkg::*;
    logic        last_q;
    logic [10:0] quiet_q;

    // ****************************************
    // Cycles since the reference last moved
    // ****************************************
    always_ff @(posedge CLK_I) begin
        last_q  <= REF_CLK_IN_I;
        quiet_q <= (!RST_B_I || REF_CLK_IN_I != last_q) ? 11'h000 : quiet_q + {10'h0, ~&quiet_q};
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence s_pair;
        CODE_UPDATE_EN_I ##1 CODE_UPDATE_EN_I;
    endsequence
    sequence s_loop_release;
        $rose(SYNC_RESET_N_I);
    endsequence

    property p_reset_quiet;
        disable iff (1'b0) !RST_B_I |=> !LOCK_O && !IRQ_O && DELAY_CODE_O == 9'h000;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared");
    property p_code_hold;
        $changed(DELAY_CODE_O) |-> $past(CODE_UPDATE_EN_I, 2) && $past(CODE_UPDATE_EN_I);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("code moved unasked");
    property p_loop_reset;
        !SYNC_RESET_N_I |=> !LOCK_O;
    endproperty
    a_loop_reset: assert property (p_loop_reset) else $error("lock in loop reset");
    property p_relock;
        s_loop_release |-> !LOCK_O [*8];
    endproperty
    a_relock: assert property (p_relock) else $error("lock too early");
    property p_lock_needs_ref;
        $rose(LOCK_O) |-> quiet_q < 11'h008;
    endproperty
    a_lock_needs_ref: assert property (p_lock_needs_ref) else $error("lock without ref");
    property p_lock_noref;
        quiet_q > 11'h12c |-> !LOCK_O;
    endproperty
    a_lock_noref: assert property (p_lock_noref) else $error("lock kept without ref");
    property p_primary_quiet;
        quiet_q > 11'h44c |-> $stable(PRIMARY_CLK_OUT_O);
    endproperty
    a_primary_quiet: assert property (p_primary_quiet) else $error("primary free running");
    property p_secondary_quiet;
        quiet_q > 11'h44c |-> $stable(SECONDARY_CLK_OUT_O);
    endproperty
    a_secondary_quiet: assert property (p_secondary_quiet) else $error("secondary moving");
    property p_delayed_quiet;
        quiet_q > 11'h44c |-> $stable(DELAYED_CLK_OUT_O);
    endproperty
    a_delayed_quiet: assert property (p_delayed_quiet) else $error("delayed moving");
    c_pair: cover property (s_pair ##1 $changed(DELAY_CODE_O));
endmodule

bind dll_delay_calibration dll_calib_sva u_sva (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .REF_CLK_IN_I(REF_CLK_IN_I),
    .SYNC_RESET_N_I(SYNC_RESET_N_I), .CODE_UPDATE_EN_I(CODE_UPDATE_EN_I),
    .DELAY_CODE_O(DELAY_CODE_O), .PRIMARY_CLK_OUT_O(PRIMARY_CLK_OUT_O),
    .SECONDARY_CLK_OUT_O(SECONDARY_CLK_OUT_O), .LOCK_O(LOCK_O),
    .DELAYED_CLK_OUT_O(DELAYED_CLK_OUT_O), .IRQ_O(IRQ_O)
);
`default_nettype wire

// ---- test/ref_clk_model.sv ----
// Reference and feedback clock source standing in front of the delay-locked loop
`timescale 1ns/1ps
`default_nettype none
module ref_clk_model (
    input  wire logic       clk_i,
    input  wire logic       run_i,
    input  wire logic [7:0] half_i,
    input  wire logic       loop_i,
    output logic            ref_o,
    output logic            fb_o
);
    logic [7:0] cnt_q;

    initial begin
        ref_o = 1'b0;
        cnt_q = 8'h00;
    end

    // Upstream clock source; stands still while not running
    always @(posedge clk_i) begin
        if (run_i) begin
            if (cnt_q == half_i - 8'h01) begin
                cnt_q <= 8'h00;
                ref_o <= ~ref_o;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // Feedback is the loop's own primary output
    assign fb_o = loop_i;
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the delay-locked loop and its registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dll_pkg::*;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] exp;
        logic        err;
    } row_s;
    logic        clk;
    logic        rst_b;
    apb_req_s    req;
    apb_rsp_s    rsp;
    logic        ref_clk;
    logic        fb_clk;
    logic        loop_rst_n;
    logic        freeze;
    logic        upd_en;
    code_t       code;
    logic        prim;
    logic        sec;
    logic        lock;
    logic        dly;
    logic        irq;
    logic        run;
    logic [7:0]  half;
    logic [31:0] r;
    logic        e;
    logic [31:0] live;
    logic [3:0]  d0;
    logic [3:0]  d1;
    logic        prev;
    int          errors;
    int          check_count;
    int          n;
    int          rises;
    row_s        rows [9] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0},
        '{1'b1, 8'h04, 32'h1ff, 32'h1ff, 1'b0}, '{1'b1, 8'h08, 32'haa, 32'haa, 1'b0},
        '{1'b1, 8'h10, 32'h1ff, 32'h0, 1'b0}, '{1'b1, 8'h20, 32'h1, 32'h0, 1'b1},
        '{1'b1, 8'h04, 32'h0, 32'h0, 1'b0}};

    always #10 clk = ~clk;

    ref_clk_model partner (
        .clk_i(clk), .run_i(run), .half_i(half), .loop_i(prim), .ref_o(ref_clk), .fb_o(fb_clk)
    );
    dll_delay_calibration dut (
        .CLK_I(clk), .RST_B_I(rst_b), .APB_REQ_I(req), .APB_RSP_O(rsp),
        .REF_CLK_IN_I(ref_clk), .FEEDBACK_CLK_IN_I(fb_clk), .SYNC_RESET_N_I(loop_rst_n),
        .UPDATE_FREEZE_I(freeze), .CODE_UPDATE_EN_I(upd_en), .DELAY_CODE_O(code),
        .PRIMARY_CLK_OUT_O(prim), .SECONDARY_CLK_OUT_O(sec), .LOCK_O(lock),
        .DELAYED_CLK_OUT_O(dly), .IRQ_O(irq)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic final_report;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        while (s !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            errors++;
            final_report();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 50);
        r = rsp.prdata;
        e = rsp.pslverr;
        if (k >= 50) begin
            errors++;
            final_report();
        end
        req <= '0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // Cycles from a primary rise to the next delayed rise, modulo the ref period
    task automatic slave_gap(input logic [31:0] ctrl, input logic [31:0] man, output logic [3:0] d);
        int m;
        wr(8'h00, ctrl);
        wr(8'h08, man);
        cycles(20);
        n = 0;
        wait_lvl(prim, 1'b0, 200);
        wait_lvl(prim, 1'b1, 200);
        m = n;
        wait_lvl(dly, 1'b0, 200);
        wait_lvl(dly, 1'b1, 200);
        d = 4'(n - m);
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        loop_rst_n = 1'b1;
        freeze = 1'b0;
        upd_en = 1'b0;
        run = 1'b0;
        half = 8'h08;
        errors = 0;
        check_count = 0;
        cycles(10);
        rst_b <= 1'b1;
        cycles(2);
        check({code, lock, irq}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].w) begin
                apb(1'b1, rows[i].a, rows[i].d);
                check(e, rows[i].err);
            end
            rd(rows[i].a);
            check(r, rows[i].exp);
            check(e, rows[i].err);
        end
        run <= 1'b1;
        n = 0;
        wait_lvl(lock, 1'b1, 4000);
        check(lock, 1'b1);
        rd(8'h1c);
        check(r, 32'h10);
        rd(8'h0c);
        check(r, 32'h31);
        freeze <= 1'b1;
        cycles(4);
        rd(8'h10);
        live = r;
        cycles(64);
        rd(8'h10);
        check(r, live);
        upd_en <= 1'b1;
        cycles(1);
        upd_en <= 1'b0;
        cycles(3);
        check(code, 32'h0);
        wr(8'h18, 32'h4);
        upd_en <= 1'b1;
        cycles(2);
        upd_en <= 1'b0;
        cycles(2);
        check(code, live[24:16]);
        check(irq, 1'b1);
        wr(8'h14, 32'h4);
        cycles(2);
        check(irq, 1'b0);
        slave_gap(32'h4, 32'h0, d0);
        slave_gap(32'h4, 32'ha, d1);
        check(4'(d1 - d0), 4'ha);
        slave_gap(32'h0, 32'h0, d1);
        check(4'(d1 - d0), live[21:18]);
        for (int k = 0; k < 3; k++) begin
            wr(8'h00, 32'(k));
            cycles(40);
            rises = 0;
            prev = sec;
            repeat (256) begin
                @(posedge clk);
                rises += int'(sec === 1'b1 && prev === 1'b0);
                prev = sec;
            end
            check(((rises << k) + 8) >> 4, 1);
        end
        loop_rst_n <= 1'b0;
        cycles(3);
        check(lock, 1'b0);
        rd(8'h10);
        check(r, {23'h0, live[24:16]});
        loop_rst_n <= 1'b1;
        freeze <= 1'b0;
        n = 0;
        wait_lvl(lock, 1'b1, 4000);
        check(lock, 1'b1);
        wr(8'h14, 32'hf);
        wr(8'h18, 32'ha);
        run <= 1'b0;
        cycles(1200);
        check(lock, 1'b0);
        check(irq, 1'b1);
        rd(8'h14);
        check(r & 32'ha, 32'ha);
        wr(8'h18, 32'h0);
        cycles(2);
        check(irq, 1'b0);
        rst_b <= 1'b0;
        cycles(2);
        rst_b <= 1'b1;
        cycles(2);
        check({code, lock, irq}, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
